// file: hdl/gpdef_top.sv
// Ports D, E and F: data latches, direction, pullups on port D only and peripheral pin sharing.
// Assumes pads outside resolve out/oe/pullup; peripherals on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "gpdef_regs.svh"

module gpdef_top
  import gpdef_pkg::*;
(
  input wire logic I_CLK_SYS,
  input wire logic I_RST_B,
  // AXI4-Lite slave
  input wire logic [`GPDEF_ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [`GPDEF_ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Pads
  input wire logic [7:0] i_port_d_pin,
  output logic [7:0] o_port_d_out,
  output logic [7:0] o_port_d_oe,
  output logic [7:0] o_port_d_pullup,
  input wire logic [5:0] i_port_e_pin,
  output logic [5:0] o_port_e_out,
  output logic [5:0] o_port_e_oe,
  input wire logic [7:0] i_port_f_pin,
  output logic [7:0] o_port_f_out,
  output logic [7:0] o_port_f_oe,
  // SPI module: per-pin ownership and drive of port D
  input wire logic [7:0] i_spi_pin_own,
  input wire logic [7:0] i_spi_pin_oe,
  input wire logic [7:0] i_spi_pin_out,
  // Serial module
  input wire logic i_serial_tx,
  output logic o_serial_rx,
  // Timer 2 channels five to two, index 3 is channel 5
  input wire logic [3:0] i_timer2_ch_out,
  input wire logic [3:0] i_timer2_ch_oe,
  output logic [3:0] o_timer2_ch_in
);

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [7:0] port_d_data_latch_q;
  logic [5:0] port_e_data_latch_q;
  logic [7:0] port_f_data_latch_q;
  logic [7:0] port_d_direction_q;
  logic [7:0] port_d_pullup_enable_q;
  logic [5:0] port_e_direction_q;
  logic [7:0] port_f_direction_q;
  logic [7:0] share_q;

  logic serial_module_enable;
  logic spi_module_enable;
  logic [3:0] timer_edge_level_select;
  assign serial_module_enable = share_q[`GPDEF_SHARE_SERIAL_EN];
  assign spi_module_enable = share_q[`GPDEF_SHARE_SPI_EN];
  assign timer_edge_level_select = share_q[`GPDEF_SHARE_TIM_LSB +: 4];

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic [21:0] pin_meta_q;
  logic [21:0] pin_sync_q;
  logic [7:0] pin_d;
  logic [5:0] pin_e;
  logic [7:0] pin_f;

  // First stage feeds only the second stage
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      pin_meta_q <= {i_port_f_pin, i_port_e_pin, i_port_d_pin};
      pin_sync_q <= pin_meta_q;
    end
  end
  assign pin_d = pin_sync_q[7:0];
  assign pin_e = pin_sync_q[13:8];
  assign pin_f = pin_sync_q[21:14];

  // ==========================================================================
  // AXI4-Lite write channel
  // ==========================================================================
  gpdef_wstate_e wstate_q;
  logic aw_held_q;
  logic w_held_q;
  logic [`GPDEF_ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic wr_fire;
  logic [11:0] wr_idx;
  logic wr_hit;
  logic wr_lane0;

  // Address and data are accepted independently, one write at a time
  assign o_awready = (wstate_q == GPDEF_W_IDLE) && !aw_held_q;
  assign o_wready = (wstate_q == GPDEF_W_IDLE) && !w_held_q;
  assign wr_fire = (wstate_q == GPDEF_W_IDLE) && aw_held_q && w_held_q;
  assign wr_idx = awaddr_q[`GPDEF_ADDR_W-1:2];
  assign wr_lane0 = wstrb_q[0];

  always_comb begin
    case (wr_idx)
      `GPDEF_IDX_D_DATA, `GPDEF_IDX_E_DATA, `GPDEF_IDX_F_DATA,
      `GPDEF_IDX_D_DIR, `GPDEF_IDX_D_PUE, `GPDEF_IDX_E_DIR,
      `GPDEF_IDX_F_DIR, `GPDEF_IDX_SHARE: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      wstate_q <= GPDEF_W_IDLE;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= `GPDEF_RESP_OKAY;
    end else begin
      case (wstate_q)
        GPDEF_W_IDLE: begin
          if (i_awvalid && o_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q <= i_awaddr;
          end
          if (i_wvalid && o_wready) begin
            w_held_q <= 1'b1;
            wdata_q <= i_wdata;
            wstrb_q <= i_wstrb;
          end
          if (wr_fire) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? `GPDEF_RESP_OKAY : `GPDEF_RESP_SLVERR;
            wstate_q <= GPDEF_W_RESP;
          end
        end
        GPDEF_W_RESP: begin
          if (i_bready) begin
            bvalid_q <= 1'b0;
            wstate_q <= GPDEF_W_IDLE;
          end
        end
        default: wstate_q <= GPDEF_W_IDLE;
      endcase
    end
  end
  assign o_bvalid = bvalid_q;
  assign o_bresp = bresp_q;

  // ==========================================================================
  // Register storage
  // ==========================================================================
  // Data latches have no reset: their power-up value is whatever the flops hold
  always_ff @(posedge I_CLK_SYS) begin
    if (wr_fire && wr_lane0) begin
      case (wr_idx)
        `GPDEF_IDX_D_DATA: port_d_data_latch_q <= wdata_q[7:0];
        `GPDEF_IDX_E_DATA: port_e_data_latch_q <= wdata_q[5:0];
        `GPDEF_IDX_F_DATA: port_f_data_latch_q <= wdata_q[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      port_d_direction_q <= `GPDEF_DIR_RESET;
      port_e_direction_q <= '0;
      port_f_direction_q <= `GPDEF_DIR_RESET;
    end else if (wr_fire && wr_lane0) begin
      case (wr_idx)
        `GPDEF_IDX_D_DIR: port_d_direction_q <= wdata_q[7:0];
        `GPDEF_IDX_E_DIR: port_e_direction_q <= wdata_q[5:0];
        `GPDEF_IDX_F_DIR: port_f_direction_q <= wdata_q[7:0];
        default: ;
      endcase
    end
  end

  // Pullup enables and sharing controls reset to off so pads start quiet
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      port_d_pullup_enable_q <= 8'h00;
      share_q <= `GPDEF_SHARE_RESET;
    end else if (wr_fire && wr_lane0) begin
      case (wr_idx)
        `GPDEF_IDX_D_PUE: port_d_pullup_enable_q <= wdata_q[7:0];
        `GPDEF_IDX_SHARE: share_q <= wdata_q[7:0];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // AXI4-Lite read channel
  // ==========================================================================
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [7:0] rd_val;
  logic rd_hit;

  assign o_arready = !rvalid_q;

  always_comb begin
    rd_val = 8'h00;
    rd_hit = 1'b1;
    case (i_araddr[`GPDEF_ADDR_W-1:2])
      `GPDEF_IDX_D_DATA:
        rd_val = (port_d_direction_q & port_d_data_latch_q)
               | (~port_d_direction_q & pin_d);
      `GPDEF_IDX_E_DATA:
        rd_val = {2'b00, (port_e_direction_q & port_e_data_latch_q)
               | (~port_e_direction_q & pin_e)};
      `GPDEF_IDX_F_DATA:
        rd_val = (port_f_direction_q & port_f_data_latch_q)
               | (~port_f_direction_q & pin_f);
      `GPDEF_IDX_D_DIR: rd_val = port_d_direction_q;
      `GPDEF_IDX_D_PUE: rd_val = port_d_pullup_enable_q;
      `GPDEF_IDX_E_DIR: rd_val = {2'b00, port_e_direction_q};
      `GPDEF_IDX_F_DIR: rd_val = port_f_direction_q;
      `GPDEF_IDX_SHARE: rd_val = share_q;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= `GPDEF_RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h00_0000, rd_val};
      rresp_q <= rd_hit ? `GPDEF_RESP_OKAY : `GPDEF_RESP_SLVERR;
    end else if (i_rready) begin
      rvalid_q <= 1'b0;
    end
  end
  assign o_rvalid = rvalid_q;
  assign o_rdata = rdata_q;
  assign o_rresp = rresp_q;

  // ==========================================================================
  // Pin drive and sharing
  // ==========================================================================
  gpdef_ovr_s ovr_e;
  gpdef_ovr_s ovr_f;
  gpdef_pad_s pad_d;
  gpdef_pad_s pad_e;
  gpdef_pad_s pad_f;
  logic [7:0] spi_own;

  // SPI ownership only counts while the SPI module is enabled
  assign spi_own = spi_module_enable ? i_spi_pin_own : 8'h00;

  always_comb begin
    ovr_e = '0;
    ovr_e.own[1] = serial_module_enable;
    ovr_e.oe[1] = 1'b0;
    ovr_e.own[0] = serial_module_enable;
    ovr_e.oe[0] = 1'b1;
    ovr_e.out[0] = i_serial_tx;
    ovr_f = '0;
    ovr_f.own[7:4] = timer_edge_level_select;
    ovr_f.oe[7:4] = i_timer2_ch_oe;
    ovr_f.out[7:4] = i_timer2_ch_out;
  end

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_pin
      always_comb begin
        pad_d.oe[g] = spi_own[g] ? i_spi_pin_oe[g] : port_d_direction_q[g];
        pad_d.out[g] = spi_own[g] ? i_spi_pin_out[g] : port_d_data_latch_q[g];
        pad_f.oe[g] = ovr_f.own[g] ? ovr_f.oe[g] : port_f_direction_q[g];
        pad_f.out[g] = ovr_f.own[g] ? ovr_f.out[g] : port_f_data_latch_q[g];
      end
      // Port E has six pins; selecting at elaboration keeps indices in range
      if (g < 6) begin : g_e
        always_comb begin
          pad_e.oe[g] = ovr_e.own[g] ? ovr_e.oe[g] : port_e_direction_q[g];
          pad_e.out[g] = ovr_e.own[g] ? ovr_e.out[g] : port_e_data_latch_q[g];
        end
      end else begin : g_e_idle
        always_comb begin
          pad_e.oe[g] = 1'b0;
          pad_e.out[g] = 1'b0;
        end
      end
    end
  endgenerate

  assign o_port_d_out = pad_d.out;
  assign o_port_d_oe = pad_d.oe;
  // Pullup follows the actual driver state, so an SPI-driven pin is not pulled
  assign o_port_d_pullup = port_d_pullup_enable_q & ~pad_d.oe;
  assign o_port_e_out = pad_e.out[5:0];
  assign o_port_e_oe = pad_e.oe[5:0];
  assign o_port_f_out = pad_f.out;
  assign o_port_f_oe = pad_f.oe;

  // Peripheral inputs see the synchronised pin, held inactive when not owned
  assign o_serial_rx = serial_module_enable ? pin_e[1] : 1'b1;
  assign o_timer2_ch_in = pin_f[7:4] & timer_edge_level_select;

endmodule
`default_nettype wire

// file: hdl/gpdef_regs.svh
// Register map, field positions and reset values of the port D/E/F block.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
`ifndef GPDEF_REGS_SVH
`define GPDEF_REGS_SVH

// Printed offsets are not all multiples of four: they are indices, byte address = 4 * index
`define GPDEF_IDX_D_DATA 12'h003
`define GPDEF_IDX_E_DATA 12'h008
`define GPDEF_IDX_F_DATA 12'h440
`define GPDEF_IDX_D_DIR 12'h004
`define GPDEF_IDX_D_PUE 12'h005
`define GPDEF_IDX_E_DIR 12'h00C
`define GPDEF_IDX_F_DIR 12'h444
`define GPDEF_IDX_SHARE 12'h450
`define GPDEF_ADDR_W 14

// Sharing control register fields
`define GPDEF_SHARE_SERIAL_EN 0
`define GPDEF_SHARE_SPI_EN 1
`define GPDEF_SHARE_TIM_LSB 4

`define GPDEF_E_WIDTH 6
`define GPDEF_D_WIDTH 8
`define GPDEF_F_WIDTH 8
`define GPDEF_DIR_RESET 8'h00
`define GPDEF_SHARE_RESET 8'h00
`define GPDEF_RESP_OKAY 2'b00
`define GPDEF_RESP_SLVERR 2'b10

`endif

// file: hdl/gpdef_pkg.sv
// Types shared by the port D/E/F block.
// Assumes gpdef_regs.svh supplies the numeric constants.
package gpdef_pkg;

  // One 8-bit port pin bundle, towards the pads
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } gpdef_pad_s;

  // Per-pin override from a peripheral that owns a pin
  typedef struct packed {
    logic [7:0] own;
    logic [7:0] oe;
    logic [7:0] out;
  } gpdef_ovr_s;

  typedef enum logic [1:0] {
    GPDEF_W_IDLE,
    GPDEF_W_RESP
  } gpdef_wstate_e;

endpackage

// file: dv/gpdef_pad_model.sv
// Pad model for one port: resolves each pin from design drive, pullup and an outside driver.
// Assumes the bench supplies the outside drive; an undriven, unpulled pin wanders each cycle.
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Pad resolution
module gpdef_pad_model #(
  parameter int W = 8
) (
  input wire logic i_clk,
  input wire logic [W-1:0] i_out,
  input wire logic [W-1:0] i_oe,
  input wire logic [W-1:0] i_pu,
  input wire logic [W-1:0] i_ext,
  input wire logic [W-1:0] i_ext_en,
  output logic [W-1:0] o_pin
);
  logic [W-1:0] float_q = '0;
  // A floating pin must never settle to a convenient level
  always @(posedge i_clk) begin
    float_q <= ~float_q;
  end
  // Design drive wins over the outside driver; a pullup only shows on a released pin
  assign o_pin = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext)
               | (~i_oe & ~i_ext_en & (i_pu | float_q));
endmodule
`default_nettype wire

// file: dv/gpdef_top_props.sv
// Checker for the port D/E/F block, watching only the top-level ports.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Assertions
module gpdef_top_props (
  input wire logic I_CLK_SYS,
  input wire logic I_RST_B,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic [1:0] o_bresp,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic [7:0] o_port_d_oe,
  input wire logic [7:0] o_port_d_pullup,
  input wire logic [5:0] o_port_e_oe,
  input wire logic [7:0] o_port_f_oe
);
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_B);
  AST_RST_OE: assert property ($rose(I_RST_B) |-> o_port_d_oe == 8'h00 && o_port_e_oe == 6'h00
    && o_port_f_oe == 8'h00 && o_port_d_pullup == 8'h00) else $error("pins driven after reset");
  AST_PU_OFF: assert property ((o_port_d_pullup & o_port_d_oe) == 8'h00)
    else $error("pullup on while driving");
  AST_BV_HOLD: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped early");
  AST_BV_DROP: assert property (o_bvalid && i_bready |=> !o_bvalid) else $error("bvalid stuck");
  AST_WR_LAT: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##[1:2] o_bvalid)
    else $error("write response late");
  AST_WR_QUIET: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write taken while response pending");
  AST_RD_LAT: assert property (i_arvalid && o_arready |=> o_rvalid) else $error("read data late");
  AST_RV_HOLD: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data changed early");
  AST_RD_HI: assert property (o_rvalid |-> o_rdata[31:8] == 24'h00_0000 && !o_arready)
    else $error("read upper bits or arready wrong");
  CVR_WR: cover property (o_bvalid && i_bready);
  CVR_RD: cover property (o_rvalid && i_rready);
  CVR_PU: cover property (o_port_d_pullup != 8'h00);
endmodule
bind gpdef_top gpdef_top_props gpdef_top_props_inst (.I_CLK_SYS, .I_RST_B, .i_awvalid,
  .o_awready, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_arvalid, .o_arready,
  .o_rdata, .o_rvalid, .i_rready, .o_port_d_oe, .o_port_d_pullup, .o_port_e_oe, .o_port_f_oe);
`default_nettype wire

// file: dv/testbench.sv
// Self-checking bench for the port D/E/F block over AXI4-Lite.
// Assumes pad models on all three ports; peripherals are driven straight from here.
`timescale 1ns/1ps
`default_nettype none
`include "gpdef_regs.svh"
// ==========================================
// Bench
module testbench;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [13:0] i_awaddr = '0, i_araddr = '0;
  logic [31:0] i_wdata = '0, o_rdata;
  logic i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0, i_serial_tx = 0;
  logic [7:0] i_spi_pin_own = '0, i_spi_pin_oe = '0, i_spi_pin_out = '0;
  logic [3:0] i_timer2_ch_out = '0, i_timer2_ch_oe = '0, o_timer2_ch_in, wstrb = 4'hF;
  logic [23:0] ext_v = '0, ext_en = '0;
  logic [7:0] i_port_d_pin, i_port_f_pin, o_port_d_out, o_port_d_oe, o_port_d_pullup;
  logic [7:0] o_port_f_out, o_port_f_oe, oe;
  logic [5:0] i_port_e_pin, o_port_e_out, o_port_e_oe;
  logic [1:0] o_bresp, o_rresp;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_serial_rx;
  int miscompares = 0, cmp_count = 0, cyc = 0;
  always #4 clk_sys = ~clk_sys;
  gpdef_top gpdef_top_inst (.I_CLK_SYS(clk_sys), .I_RST_B(rst_b), .i_awaddr, .i_awvalid,
    .o_awready, .i_wdata, .i_wstrb(wstrb), .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
    .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_port_d_pin,
    .o_port_d_out, .o_port_d_oe, .o_port_d_pullup, .i_port_e_pin, .o_port_e_out, .o_port_e_oe,
    .i_port_f_pin, .o_port_f_out, .o_port_f_oe, .i_spi_pin_own, .i_spi_pin_oe, .i_spi_pin_out,
    .i_serial_tx, .o_serial_rx, .i_timer2_ch_out, .i_timer2_ch_oe, .o_timer2_ch_in);
  gpdef_pad_model #(.W(8)) pad_d (.i_clk(clk_sys), .i_out(o_port_d_out), .i_oe(o_port_d_oe),
    .i_pu(o_port_d_pullup), .i_ext(ext_v[7:0]), .i_ext_en(ext_en[7:0]), .o_pin(i_port_d_pin));
  gpdef_pad_model #(.W(6)) pad_e (.i_clk(clk_sys), .i_out(o_port_e_out), .i_oe(o_port_e_oe),
    .i_pu(6'h00), .i_ext(ext_v[13:8]), .i_ext_en(ext_en[13:8]), .o_pin(i_port_e_pin));
  gpdef_pad_model #(.W(8)) pad_f (.i_clk(clk_sys), .i_out(o_port_f_out), .i_oe(o_port_f_oe),
    .i_pu(8'h00), .i_ext(ext_v[23:16]), .i_ext_en(ext_en[23:16]), .o_pin(i_port_f_pin));
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] er = 2'b00);
    @(posedge clk_sys);
    i_awaddr <= {idx, 2'b00};
    i_wdata <= {24'h00_0000, d};
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
    end while (!o_bvalid);
    chk("bresp", 32'(o_bresp), 32'(er));
    i_bready <= 1'b0;
  endtask
  task rc(input string nm, input logic [11:0] idx, input logic [31:0] exp,
          input logic [1:0] er = 2'b00);
    @(posedge clk_sys);
    i_araddr <= {idx, 2'b00};
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (o_arready) i_arvalid <= 1'b0;
    end while (!o_rvalid);
    chk("rresp", 32'(o_rresp), 32'(er));
    chk(nm, o_rdata, exp);
    i_rready <= 1'b0;
  endtask
  task t_reset;
    rc("dir_d", `GPDEF_IDX_D_DIR, 32'h0000_0000);
    rc("dir_e", `GPDEF_IDX_E_DIR, 32'h0000_0000);
    rc("dir_f", `GPDEF_IDX_F_DIR, 32'h0000_0000);
    chk("oe_all", 32'({o_port_d_oe, o_port_e_oe, o_port_f_oe}), 32'h0000_0000);
    rc("unmapped", 12'h001, 32'h0000_0000, 2'b10);
    wr(12'h001, 8'hFF, 2'b10);
    $display("test reset done");
  endtask
  // One port: input reads, latch written while input, then mixed direction
  task t_port(input int p, input logic [11:0] di, input logic [11:0] ri, input logic [7:0] m);
    ext_en[8*p+:8] <= 8'hFF;
    ext_v[8*p+:8] <= 8'h96;
    wr(ri, 8'h00);
    wr(di, 8'h5A);
    repeat (3) @(posedge clk_sys);
    rc("pin", di, 32'(8'h96 & m));
    wr(ri, 8'hC3);
    rc("dir", ri, 32'(8'hC3 & m));
    rc("mix", di, 32'(8'h56 & m));
    oe = p == 0 ? o_port_d_oe : p == 1 ? {2'b00, o_port_e_oe} : o_port_f_oe;
    chk("oe", 32'(oe), 32'(8'hC3 & m));
    $display("test port %0d done", p);
  endtask
  task t_pullup;
    ext_en[7:0] <= 8'h00;
    wr(`GPDEF_IDX_D_DIR, 8'hF0);
    wr(`GPDEF_IDX_D_PUE, 8'hFF);
    chk("pullup", 32'(o_port_d_pullup), 32'h0000_000F);
    repeat (3) @(posedge clk_sys);
    rc("pulled", `GPDEF_IDX_D_DATA, 32'h0000_005F);
    rc("pue", `GPDEF_IDX_D_PUE, 32'h0000_00FF);
    wr(`GPDEF_IDX_D_PUE, 8'h00);
    chk("pullup_off", 32'(o_port_d_pullup), 32'h0000_0000);
    $display("test pullup done");
  endtask
  task t_serial;
    ext_v[9] <= 1'b0;
    wr(`GPDEF_IDX_E_DIR, 8'h00);
    wr(`GPDEF_IDX_SHARE, 8'h01);
    i_serial_tx <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("rx", 32'(o_serial_rx), 32'h0000_0000);
    chk("e_oe", 32'(o_port_e_oe[1:0]), 32'h0000_0001);
    chk("tx", 32'(o_port_e_out[0]), 32'h0000_0001);
    rc("e_shared", `GPDEF_IDX_E_DATA, 32'h0000_0015);
    wr(`GPDEF_IDX_SHARE, 8'h00);
    chk("rx_idle", 32'(o_serial_rx), 32'h0000_0001);
    chk("e_oe_gp", 32'(o_port_e_oe), 32'h0000_0000);
    $display("test serial done");
  endtask
  task t_periph;
    wr(`GPDEF_IDX_F_DIR, 8'h00);
    wr(`GPDEF_IDX_SHARE, 8'hF0);
    i_timer2_ch_oe <= 4'h6;
    i_timer2_ch_out <= 4'hA;
    repeat (4) @(posedge clk_sys);
    chk("f_oe", 32'(o_port_f_oe), 32'h0000_0060);
    chk("f_out", 32'(o_port_f_out[6:5]), 32'h0000_0001);
    chk("tim_in", 32'(o_timer2_ch_in), 32'h0000_000B);
    wr(`GPDEF_IDX_D_DIR, 8'h0F);
    wr(`GPDEF_IDX_SHARE, 8'h02);
    i_spi_pin_own <= 8'hF0;
    i_spi_pin_oe <= 8'h30;
    i_spi_pin_out <= 8'hA0;
    @(posedge clk_sys);
    @(posedge clk_sys);
    chk("d_oe", 32'(o_port_d_oe), 32'h0000_003F);
    chk("d_out", 32'(o_port_d_out), 32'h0000_00AA);
    wr(`GPDEF_IDX_SHARE, 8'h00);
    chk("tim_off", 32'(o_timer2_ch_in), 32'h0000_0000);
    $display("test peripherals done");
  endtask
  task t_rst_keep;
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    rc("dir_rst", `GPDEF_IDX_D_DIR, 32'h0000_0000);
    wr(`GPDEF_IDX_D_DIR, 8'hFF);
    rc("latch_kept", `GPDEF_IDX_D_DATA, 32'h0000_005A);
    // Low byte lane disabled: response still OKAY, latch must not change
    wstrb <= 4'hE;
    wr(`GPDEF_IDX_D_DATA, 8'h11);
    wstrb <= 4'hF;
    rc("strb_skip", `GPDEF_IDX_D_DATA, 32'h0000_005A);
    $display("test reset keeps latches done");
  endtask
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // A hang ends as a mismatch; the full run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_reset();
    t_port(0, `GPDEF_IDX_D_DATA, `GPDEF_IDX_D_DIR, 8'hFF);
    t_port(1, `GPDEF_IDX_E_DATA, `GPDEF_IDX_E_DIR, 8'h3F);
    t_port(2, `GPDEF_IDX_F_DATA, `GPDEF_IDX_F_DIR, 8'hFF);
    t_pullup();
    t_serial();
    t_periph();
    t_rst_keep();
    tally_and_finish();
  end
endmodule
`default_nettype wire
